//--- verif/ssp_peer.sv
// far side peer: echoes transmit data back and captures the three data lines
`timescale 1ns/10ps
module ssp_peer (
	// device pins
	input wire ssp_pkg::ssp_pin_vec_t pin_drive,
	input wire ssp_pkg::ssp_pin_vec_t pin_oe,
	// bench levels for pins the device leaves free
	input wire ssp_pkg::ssp_pin_vec_t ext_level,
	// resolved wires and what the peer saw
	output ssp_pkg::ssp_pin_vec_t pin_level,
	output ssp_pkg::ssp_tx_word_t cap,
	output int edge_cnt
);
	ssp_pkg::ssp_pin_vec_t far_val;
	int edge_q = 0;
	// echo keeps receive data tied to a known pattern; frame sync input comes from ext
	always_comb begin
		far_val = ext_level;
		far_val[1] = pin_oe[0] ? pin_drive[0] : ext_level[1];
	end
	assign pin_level = (pin_oe & pin_drive) | (~pin_oe & far_val);
	assign edge_cnt = edge_q;
	// sample on the rising bit clock, whether it runs gated or continuous
	always @(posedge pin_level[2]) begin
		edge_q <= edge_q + 1;
		cap.ch0 <= {cap.ch0[14:0], pin_level[0]};
		cap.ch1 <= {cap.ch1[14:0], pin_level[3]};
		cap.ch2 <= {cap.ch2[14:0], pin_level[4]};
	end
endmodule : ssp_peer

//--- verif/ssp_pin_port_assertions.sv
// concurrent checks on the sync serial port pins and word streams
`timescale 1ns/10ps
module ssp_chk #(
	parameter int WORD_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// observed ports
	input wire ssp_pkg::ssp_cfg_t cfg,
	input wire ssp_pkg::ssp_pin_vec_t gpio_dir,
	input wire ssp_pkg::ssp_pin_vec_t gpio_out,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic rx_valid,
	input wire logic [WORD_W-1:0] rx_word,
	input wire ssp_pkg::ssp_pin_vec_t pin_drive,
	input wire ssp_pkg::ssp_pin_vec_t pin_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// registered pin controls need a few quiet cycles out of reset
	sequence cfg_held;
		(rst_n && $stable(cfg)) [*3];
	endsequence
	gpio_dir_a:
	assert property (cfg_held ##0 !cfg.port_en |-> pin_oe == $past(gpio_dir))
		else $error("aux io enable wrong");
	gpio_val_a:
	assert property (cfg_held ##0 !cfg.port_en |->
		(pin_drive & pin_oe) == ($past(gpio_out) & $past(gpio_dir))) else $error("aux io value wrong");
	data_dir_a:
	assert property (cfg.port_en |-> pin_oe[0] && !pin_oe[1]) else $error("data pin direction wrong");
	bclk_dir_a:
	assert property (cfg.port_en |-> pin_oe[2] == cfg.bclk_out) else $error("bit clock direction");
	fs_dir_a:
	assert property (cfg.port_en |-> pin_oe[5] == cfg.fs_out) else $error("frame sync direction");
	ctrl_a_fn_a:
	assert property (cfg.port_en |-> pin_oe[3] ==
		(cfg.sync_mode ? (cfg.tx1_en | cfg.flag0_out) : cfg.rxclk_out)) else $error("ctrl a function");
	ctrl_b_fn_a:
	assert property (cfg.port_en |-> pin_oe[4] ==
		(cfg.sync_mode ? (cfg.tx2_en | cfg.flag1_out) : cfg.rx_fs_out)) else $error("ctrl b function");
	flag_val_a:
	assert property (cfg_held ##0 cfg.port_en && cfg.sync_mode && !cfg.tx1_en && cfg.flag0_out |->
		pin_drive[3] == cfg.flag0_val) else $error("flag 0 value wrong");
	tx_take_a:
	assert property (tx_valid && tx_ready |=> !tx_ready) else $error("word taken twice");
	rx_pulse_a:
	assert property (rx_valid |=> !rx_valid [*8]) else $error("receive pulse too close");
	rx_hold_a:
	assert property ($changed(rx_word) |-> rx_valid) else $error("receive word moved alone");
endmodule : ssp_chk
bind ssp_pin_port ssp_chk #(.WORD_W(WORD_W)) u_chk (.clk, .rst_n, .cfg, .gpio_dir, .gpio_out,
	.tx_valid, .tx_ready, .rx_valid, .rx_word, .pin_drive, .pin_oe);

//--- verif/sync_serial_pin_functions_tb_top.sv
// self-checking bench for the sync serial pin function block
`timescale 1ns/10ps
module sync_serial_pin_functions_tb_top;
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst_n = 1'b0;
	logic tx_valid = 1'b0;
	logic tx_ready, rx_valid;
	logic [15:0] rx_word;
	ssp_pkg::ssp_cfg_t cfg = '0;
	ssp_pkg::ssp_pin_vec_t gpio_dir = 6'h00, gpio_out = 6'h00, ext_level = 6'h00;
	ssp_pkg::ssp_pin_vec_t gpio_in, pin_level, pin_drive, pin_oe;
	ssp_pkg::ssp_tx_word_t tx_word = '0;
	ssp_pkg::ssp_tx_word_t cap;
	int edge_cnt, e0;
	int error_cnt = 0;
	int compares = 0;

	// link clock offset so the two clocks never share edges
	initial begin
		forever #5 clk = ~clk;
	end
	initial begin
		#3.7;
		forever #15 link_clk = ~link_clk;
	end

	ssp_pin_port uut (.clk, .rst_n, .link_clk, .cfg, .gpio_dir, .gpio_out, .gpio_in, .tx_valid,
		.tx_ready, .tx_word, .rx_valid, .rx_word, .pin_level, .pin_drive, .pin_oe);
	ssp_peer peer (.pin_drive, .pin_oe, .ext_level, .pin_level, .cap, .edge_cnt);

	task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t %s: got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic conclude;
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : conclude

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	// bounded wait for tx_ready or an rx_valid pulse
	task automatic wait_for(input bit rx, input int lim);
		int n = 0;
		while ((rx ? rx_valid : tx_ready) !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > lim) begin
				error_cnt++;
				$display("[ERR] %0t wait timed out", $time);
				conclude();
			end
		end
	endtask : wait_for

	task automatic send(input ssp_pkg::ssp_tx_word_t w);
		wait_for(1'b0, 200);
		tx_word = w;
		tx_valid = 1'b1;
		cyc(1);
		tx_valid = 1'b0;
	endtask : send

	task automatic t_gpio;
		cfg = '0;
		gpio_dir = 6'h2A;
		gpio_out = 6'h0F;
		ext_level = 6'h15;
		cyc(6);
		chk(pin_oe, 6'h2A, "aux enable");
		chk(pin_drive & 6'h2A, 6'h0A, "aux drive");
		chk(gpio_in, 6'h1F, "aux input");
		$display("aux io test done");
	endtask : t_gpio

	// two words back to back; the second is taken while the first is on the wire
	task automatic t_sync;
		cfg = '{port_en:1, sync_mode:1, bclk_out:1, bclk_gated:1, fs_out:1, tx1_en:1, tx2_en:1,
			default:0};
		cyc(8);
		e0 = edge_cnt;
		chk(pin_oe, 6'h3D, "sync enables");
		send({16'h3C5A, 16'h9E01, 16'h1234});
		send({16'h0FF1, 16'h8001, 16'hA5C3});
		wait_for(1'b1, 300);
		chk(rx_word, 16'h1234, "rx word 1");
		cyc(1);
		wait_for(1'b1, 300);
		chk(rx_word, 16'hA5C3, "rx word 2");
		cyc(40);
		chk(cap, {16'h0FF1, 16'h8001, 16'hA5C3}, "tx lines");
		chk(edge_cnt - e0, 32, "gated edges");
		$display("sync transfer test done");
	endtask : t_sync

	task automatic t_flags;
		cfg = '{port_en:1, sync_mode:1, bclk_out:1, bclk_gated:1, fs_out:1, flag0_out:1,
			flag1_out:1, flag0_val:1, default:0};
		cyc(8);
		chk({pin_oe[4:3], pin_drive[4:3]}, 4'hD, "flag outputs");
		cfg.flag0_out = 1'b0;
		cfg.flag1_out = 1'b0;
		ext_level = 6'h18;
		cyc(6);
		chk({pin_oe[4:3], gpio_in[4:3]}, 4'h3, "flag inputs");
		$display("flag test done");
	endtask : t_flags

	// async: tx1_en stays set to show the mode bit alone decides ctrl_pin_a
	task automatic t_async;
		cfg = '{port_en:1, bclk_out:1, bclk_gated:1, fs_out:1, rxclk_out:1, rx_fs_out:1,
			tx1_en:1, default:0};
		cyc(4);
		chk(pin_oe, 6'h3D, "async outputs");
		cfg.rxclk_out = 1'b0;
		cfg.rx_fs_out = 1'b0;
		cfg.fs_out = 1'b0;
		cyc(4);
		chk(pin_oe, 6'h05, "async inputs");
		$display("async test done");
	endtask : t_async

	// continuous clock with no word pending sends zero frames
	task automatic t_cont;
		cfg = '{port_en:1, sync_mode:1, bclk_out:1, fs_out:1, default:0};
		e0 = edge_cnt;
		cyc(100);
		chk(edge_cnt - e0 >= 30, 1, "continuous edges");
		wait_for(1'b1, 300);
		chk(rx_word, 16'h0000, "idle frame word");
		$display("continuous clock test done");
	endtask : t_cont

	// outside frame sync on frame_sync_pin times both directions in sync mode
	task automatic t_extfs;
		cfg = '{port_en:1, sync_mode:1, bclk_out:1, tx1_en:1, tx2_en:1, default:0};
		cyc(8);
		send({16'h5A0F, 16'hC3E1, 16'h8421});
		cyc(60);
		chk(tx_ready, 1'b0, "word held for sync");
		@(negedge link_clk);
		ext_level[5] = 1'b1;
		@(negedge link_clk);
		ext_level[5] = 1'b0;
		wait_for(1'b1, 300);
		chk(rx_word, 16'h8421, "outside sync word");
		chk(tx_ready, 1'b1, "outside sync ack");
		$display("outside frame sync test done");
	endtask : t_extfs

	// reset for 16 cycles, then each scenario in turn
	initial begin
		cyc(16);
		rst_n = 1'b1;
		cyc(4);
		t_gpio();
		t_sync();
		t_flags();
		t_async();
		t_cont();
		t_extfs();
		conclude();
	end
endmodule : sync_serial_pin_functions_tb_top

//--- verilog/ssp_pin_port.sv
// sync serial port with pin function selection and aux io fallback
//
// Function
// - bit clock pin driven when bclk_out, else an unused input; link_clk times transmit, sync receive
// - bit clock continuous or gated to transfers
// - async: ctrl_pin_a is receive clock in/out
// - sync: ctrl_pin_a is transmit channel 1 or flag0
// - async: ctrl_pin_b is receive frame sync in/out
// - sync: ctrl_pin_b is transmit channel 2 or flag1
// - frame_sync_pin frames tx, and rx when sync
// - frame sync output is internally generated
// - tx_serial_out shifts from transmit shift register
// - rx_serial_in samples into receive shift register
// - unused port: every pin is aux io
`timescale 1ns/10ps
module ssp_pin_port #(
	parameter int WORD_W = ssp_pkg::WORD_W
) (
	// system clock domain
	input wire logic clk,
	input wire logic rst_n,
	// link bit clock domain
	input wire logic link_clk,
	// configuration and aux io control
	input wire ssp_pkg::ssp_cfg_t cfg,
	input wire ssp_pkg::ssp_pin_vec_t gpio_dir,
	input wire ssp_pkg::ssp_pin_vec_t gpio_out,
	output ssp_pkg::ssp_pin_vec_t gpio_in,
	// transmit word stream
	input wire logic tx_valid,
	output logic tx_ready,
	input wire ssp_pkg::ssp_tx_word_t tx_word,
	// receive word stream
	output logic rx_valid,
	output logic [WORD_W-1:0] rx_word,
	// pins: level seen, level driven, drive enable
	input wire ssp_pkg::ssp_pin_vec_t pin_level,
	output ssp_pkg::ssp_pin_vec_t pin_drive,
	output ssp_pkg::ssp_pin_vec_t pin_oe
);

	// ---------------- system domain state ----------------
	logic tx_req_ff;
	ssp_pkg::ssp_tx_word_t tx_buf_ff;
	logic tx_ack_s;
	logic rx_seen_ff;
	logic rx_tgl_s;
	logic rx_valid_ff;
	logic [WORD_W-1:0] rx_word_ff;
	ssp_pkg::ssp_pin_vec_t gpio_dir_ff;
	ssp_pkg::ssp_pin_vec_t gpio_out_ff;

	// ---------------- link domain state ----------------
	logic lrst_meta_ff;
	logic lrst_n_ff;
	ssp_pkg::ssp_cfg_t cfg_l;
	logic tx_req_l;
	logic tx_ack_ff;
	logic [ssp_pkg::BIT_CNT_W-1:0] fs_cnt_ff;
	logic fs_ff;
	logic busy_ff;
	logic [ssp_pkg::BIT_CNT_W-1:0] bit_cnt_ff;
	logic [WORD_W-1:0] sh0_ff;
	logic [WORD_W-1:0] sh1_ff;
	logic [WORD_W-1:0] sh2_ff;
	logic gate_ff;
	logic rxd_neg_ff;
	logic rxck_s;
	logic rxck_d_ff;
	logic rx_busy_ff;
	logic [ssp_pkg::BIT_CNT_W-1:0] rx_cnt_ff;
	logic [WORD_W-1:0] rx_sh_ff;
	logic [WORD_W-1:0] rx_hold_ff;
	logic rx_tgl_ff;

	// ================= system domain =================

	// transmit handoff: a word is held until the link domain acknowledges it,
	// so the buffer is stable whenever the link side reads it
	wire tx_take = tx_valid & tx_ready;
	assign tx_ready = (tx_req_ff == tx_ack_s);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_req_ff <= 1'b0;
			tx_buf_ff <= '0;
		end else if (tx_take) begin
			tx_req_ff <= ~tx_req_ff;
			tx_buf_ff <= tx_word;
		end
	end

	ssp_sync #(.WIDTH(1)) u_ack_sync (
		.dst_clk(clk),
		.dst_rst_n(rst_n),
		.d(tx_ack_ff),
		.q(tx_ack_s)
	);

	// receive handoff: toggle crosses, hold word is stable for a whole frame
	ssp_sync #(.WIDTH(1)) u_rxtgl_sync (
		.dst_clk(clk),
		.dst_rst_n(rst_n),
		.d(rx_tgl_ff),
		.q(rx_tgl_s)
	);

	wire rx_new = rx_tgl_s ^ rx_seen_ff;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_seen_ff <= 1'b0;
			rx_valid_ff <= 1'b0;
			rx_word_ff <= ssp_pkg::WORD_RST;
		end else begin
			rx_seen_ff <= rx_tgl_s;
			rx_valid_ff <= rx_new;
			if (rx_new) begin
				rx_word_ff <= rx_hold_ff;
			end
		end
	end

	assign rx_valid = rx_valid_ff;
	assign rx_word = rx_word_ff;

	// aux io registers; pin levels are foreign, so they pass two flops
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gpio_dir_ff <= ssp_pkg::GPIO_DIR_RST;
			gpio_out_ff <= ssp_pkg::GPIO_OUT_RST;
		end else begin
			gpio_dir_ff <= gpio_dir;
			gpio_out_ff <= gpio_out;
		end
	end

	ssp_sync #(.WIDTH(ssp_pkg::NUM_PINS)) u_gpio_sync (
		.dst_clk(clk),
		.dst_rst_n(rst_n),
		.d(pin_level),
		.q(gpio_in)
	);

	// ================= link domain =================

	// link reset follows rst_n through two link flops; rst_n must be held
	// long enough to span several link clock edges
	always_ff @(posedge link_clk) begin
		lrst_meta_ff <= rst_n;
		lrst_n_ff <= lrst_meta_ff;
	end

	// configuration is quasi static, so a plain level sync per bit is enough
	ssp_sync #(.WIDTH(ssp_pkg::CFG_W)) u_cfg_sync (
		.dst_clk(link_clk),
		.dst_rst_n(lrst_n_ff),
		.d(cfg),
		.q(cfg_l)
	);

	ssp_sync #(.WIDTH(1)) u_req_sync (
		.dst_clk(link_clk),
		.dst_rst_n(lrst_n_ff),
		.d(tx_req_ff),
		.q(tx_req_l)
	);

	// external receive clock on ctrl_pin_a is foreign to link_clk
	ssp_sync #(.WIDTH(1)) u_rxck_sync (
		.dst_clk(link_clk),
		.dst_rst_n(lrst_n_ff),
		.d(pin_level[ssp_pkg::PIN_CTRL_A]),
		.q(rxck_s)
	);

	wire tx_pend = tx_req_l ^ tx_ack_ff;
	wire async_mode = ~cfg_l.sync_mode;

	// internal frame generator; in gated form frames run only with data waiting
	wire fs_run = cfg_l.port_en & (~cfg_l.bclk_gated | tx_pend);
	wire fs_cnt_zero = (fs_cnt_ff == ssp_pkg::CNT_ZERO);
	wire int_start = fs_run & fs_cnt_zero;

	// transmit frame start: own sync when driving, far party's when not
	wire ext_fs = pin_level[ssp_pkg::PIN_FS];
	wire tx_start = cfg_l.port_en & (cfg_l.fs_out ? int_start : ext_fs);

	// receive frame start: shared in sync mode, ctrl_pin_b in async mode
	wire rx_fs_ext = pin_level[ssp_pkg::PIN_CTRL_B];
	wire rx_fs_async = cfg_l.rx_fs_out ? int_start : rx_fs_ext;
	wire rx_start_raw = cfg_l.sync_mode ? tx_start : rx_fs_async;

	// receive bit tick: every bit clock in sync mode, ctrl_pin_a edge in
	// async mode with an outside clock, which must be below half link rate;
	// the edge detector resets low, so an outside clock that idles high
	// gives one early tick after reset
	wire rxck_rise = rxck_s & ~rxck_d_ff;
	wire ext_rxck = async_mode & ~cfg_l.rxclk_out;
	wire rx_tick = ext_rxck ? rxck_rise : 1'b1;
	wire rx_start = cfg_l.port_en & rx_start_raw & rx_tick;
	wire bit_last = (bit_cnt_ff == ssp_pkg::CNT_ZERO);
	wire rx_last = (rx_cnt_ff == ssp_pkg::CNT_ZERO);

	always_ff @(posedge link_clk) begin
		if (!lrst_n_ff) begin
			fs_cnt_ff <= ssp_pkg::CNT_ZERO;
			fs_ff <= 1'b0;
		end else begin
			fs_ff <= int_start;
			if (int_start) begin
				fs_cnt_ff <= ssp_pkg::LAST_BIT;
			end else if (!fs_cnt_zero) begin
				fs_cnt_ff <= fs_cnt_ff - 1'b1;
			end
		end
	end

	// transmit shifters: load at frame start, then one bit per bit clock,
	// msb first; an empty frame sends zeros and leaves the word waiting;
	// a frame start always reloads, so an outside sync mid-frame cuts it
	always_ff @(posedge link_clk) begin
		if (!lrst_n_ff) begin
			busy_ff <= 1'b0;
			bit_cnt_ff <= ssp_pkg::CNT_ZERO;
			tx_ack_ff <= 1'b0;
			sh0_ff <= ssp_pkg::WORD_RST;
			sh1_ff <= ssp_pkg::WORD_RST;
			sh2_ff <= ssp_pkg::WORD_RST;
		end else if (tx_start) begin
			busy_ff <= 1'b1;
			bit_cnt_ff <= ssp_pkg::LAST_BIT;
			tx_ack_ff <= tx_ack_ff ^ tx_pend;
			sh0_ff <= tx_pend ? tx_buf_ff.ch0 : ssp_pkg::WORD_RST;
			sh1_ff <= tx_pend ? tx_buf_ff.ch1 : ssp_pkg::WORD_RST;
			sh2_ff <= tx_pend ? tx_buf_ff.ch2 : ssp_pkg::WORD_RST;
		end else if (busy_ff) begin
			busy_ff <= ~bit_last;
			bit_cnt_ff <= bit_cnt_ff - 1'b1;
			sh0_ff <= {sh0_ff[WORD_W-2:0], 1'b0};
			sh1_ff <= {sh1_ff[WORD_W-2:0], 1'b0};
			sh2_ff <= {sh2_ff[WORD_W-2:0], 1'b0};
		end
	end

	// next busy state, so the gate opens with the first bit and shuts after the last
	wire nxt_busy = tx_start | (busy_ff & ~bit_last);

	// the gate moves on the rising link edge, while the driven clock is low;
	// switching it as the driven clock rises would leave a runt pulse
	always_ff @(posedge link_clk) begin
		if (!lrst_n_ff) begin
			gate_ff <= 1'b0;
		end else begin
			gate_ff <= cfg_l.bclk_gated ? nxt_busy : 1'b1;
		end
	end

	// received data sampled mid-bit, on the falling link edge
	always_ff @(negedge link_clk) begin
		if (!lrst_n_ff) begin
			rxd_neg_ff <= 1'b0;
		end else begin
			rxd_neg_ff <= pin_level[ssp_pkg::PIN_RXD];
		end
	end

	// receive shifter and word handoff; a start on the edge that shifts the
	// last bit is taken, so back to back frames lose no word
	wire rx_free = ~rx_busy_ff | rx_last;
	wire [WORD_W-1:0] rx_sh_nxt = {rx_sh_ff[WORD_W-2:0], rxd_neg_ff};

	always_ff @(posedge link_clk) begin
		if (!lrst_n_ff) begin
			rxck_d_ff <= 1'b0;
			rx_busy_ff <= 1'b0;
			rx_cnt_ff <= ssp_pkg::CNT_ZERO;
			rx_sh_ff <= ssp_pkg::WORD_RST;
			rx_hold_ff <= ssp_pkg::WORD_RST;
			rx_tgl_ff <= 1'b0;
		end else begin
			rxck_d_ff <= rxck_s;
			if (rx_busy_ff && rx_tick) begin
				rx_sh_ff <= rx_sh_nxt;
				rx_cnt_ff <= rx_cnt_ff - 1'b1;
				rx_busy_ff <= ~rx_last;
				if (rx_last) begin
					rx_hold_ff <= rx_sh_nxt;
					rx_tgl_ff <= ~rx_tgl_ff;
				end
			end
			// a new start overrides the end of the word just finished
			if (rx_start && rx_free) begin
				rx_busy_ff <= 1'b1;
				rx_cnt_ff <= ssp_pkg::LAST_BIT;
			end
		end
	end

	// ================= pin function selection =================

	// the driven bit clock falls as each bit is launched; peers sample on rise
	wire bclk_drv = ~link_clk & gate_ff;

	// ctrl_pin_a: async receive clock, or sync channel 1 / flag 0
	wire ca_sync_drv = cfg.tx1_en ? sh1_ff[WORD_W-1] : cfg.flag0_val;
	wire ca_sync_oe = cfg.tx1_en | cfg.flag0_out;
	wire ca_drv = cfg.sync_mode ? ca_sync_drv : bclk_drv;
	wire ca_oe = cfg.sync_mode ? ca_sync_oe : cfg.rxclk_out;

	// ctrl_pin_b: async receive frame sync, or sync channel 2 / flag 1
	wire cb_sync_drv = cfg.tx2_en ? sh2_ff[WORD_W-1] : cfg.flag1_val;
	wire cb_sync_oe = cfg.tx2_en | cfg.flag1_out;
	wire cb_drv = cfg.sync_mode ? cb_sync_drv : fs_ff;
	wire cb_oe = cfg.sync_mode ? cb_sync_oe : cfg.rx_fs_out;

	// serial function of each pin, gathered by pin position
	ssp_pkg::ssp_pin_vec_t ser_drv;
	ssp_pkg::ssp_pin_vec_t ser_oe;

	assign ser_drv[ssp_pkg::PIN_TXD] = sh0_ff[WORD_W-1];
	assign ser_oe[ssp_pkg::PIN_TXD] = 1'b1;
	assign ser_drv[ssp_pkg::PIN_RXD] = 1'b0;
	assign ser_oe[ssp_pkg::PIN_RXD] = 1'b0;
	assign ser_drv[ssp_pkg::PIN_BCLK] = bclk_drv;
	assign ser_oe[ssp_pkg::PIN_BCLK] = cfg.bclk_out;
	assign ser_drv[ssp_pkg::PIN_CTRL_A] = ca_drv;
	assign ser_oe[ssp_pkg::PIN_CTRL_A] = ca_oe;
	assign ser_drv[ssp_pkg::PIN_CTRL_B] = cb_drv;
	assign ser_oe[ssp_pkg::PIN_CTRL_B] = cb_oe;
	assign ser_drv[ssp_pkg::PIN_FS] = fs_ff;
	assign ser_oe[ssp_pkg::PIN_FS] = cfg.fs_out;

	// each pin falls back to its own aux io bit while the port is off
	genvar gi;
	generate
		for (gi = 0; gi < ssp_pkg::NUM_PINS; gi++) begin : g_pin
			assign pin_drive[gi] = cfg.port_en ? ser_drv[gi] : gpio_out_ff[gi];
			assign pin_oe[gi] = cfg.port_en ? ser_oe[gi] : gpio_dir_ff[gi];
		end
	endgenerate

endmodule : ssp_pin_port

//--- verilog/ssp_pkg.sv
// shared constants and carrier types for the sync serial pin function block
package ssp_pkg;

	// word and frame geometry
	localparam int WORD_W = 16;
	localparam int FRAME_BITS = 16;
	localparam int BIT_CNT_W = $clog2(FRAME_BITS);
	localparam logic [BIT_CNT_W-1:0] LAST_BIT = BIT_CNT_W'(FRAME_BITS - 1);
	localparam logic [BIT_CNT_W-1:0] CNT_ZERO = '0;

	// synchroniser depth of ssp_sync; receive data and frame sync pins bypass it
	localparam int SYNC_STAGES = 2;

	// pin positions inside the pin vectors
	localparam int NUM_PINS = 6;
	localparam int PIN_TXD = 0;
	localparam int PIN_RXD = 1;
	localparam int PIN_BCLK = 2;
	localparam int PIN_CTRL_A = 3;
	localparam int PIN_CTRL_B = 4;
	localparam int PIN_FS = 5;

	// reset values
	localparam logic [NUM_PINS-1:0] GPIO_DIR_RST = 6'h00;
	localparam logic [NUM_PINS-1:0] GPIO_OUT_RST = 6'h00;
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

	typedef logic [NUM_PINS-1:0] ssp_pin_vec_t;

	// static configuration; change only while no frame is running
	typedef struct packed {
		logic port_en;    // 1: serial port owns the pins, 0: all pins are aux io
		logic sync_mode;  // 1: synchronous, 0: asynchronous
		logic bclk_out;   // device sources the bit clock
		logic bclk_gated; // bit clock only runs during transfers
		logic rxclk_out;  // async: receive clock driven on ctrl_pin_a
		logic rx_fs_out;  // async: receive frame sync driven on ctrl_pin_b
		logic fs_out;     // frame sync generated internally and driven
		logic tx1_en;     // sync: ctrl_pin_a carries transmit channel 1
		logic tx2_en;     // sync: ctrl_pin_b carries transmit channel 2
		logic flag0_out;  // sync: flag 0 is an output
		logic flag1_out;  // sync: flag 1 is an output
		logic flag0_val;
		logic flag1_val;
	} ssp_cfg_t;

	localparam int CFG_W = $bits(ssp_cfg_t);

	// one frame worth of transmit data, one word per channel
	typedef struct packed {
		logic [WORD_W-1:0] ch2;
		logic [WORD_W-1:0] ch1;
		logic [WORD_W-1:0] ch0;
	} ssp_tx_word_t;

	localparam int TXW_W = $bits(ssp_tx_word_t);

endpackage : ssp_pkg

//--- verilog/ssp_sync.sv
// multi-bit two-stage synchroniser for levels and toggles
`timescale 1ns/10ps
module ssp_sync #(
	parameter int WIDTH = 1
) (
	// destination domain
	input wire logic dst_clk,
	input wire logic dst_rst_n,
	// data
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// first stage is read only by the second stage
	always_ff @(posedge dst_clk) begin
		if (!dst_rst_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end

	assign q = sync_ff;

endmodule : ssp_sync
